// ==== pfc_defs.vh ====
// Constants for the dual-slope frequency-correct PWM timer
`ifndef PFC_DEFS_VH
`define PFC_DEFS_VH

// Register byte offsets
`define PFC_OFS_CTRL 12'h000
`define PFC_OFS_COUNT 12'h004
`define PFC_OFS_CMPA 12'h008
`define PFC_OFS_CMPB 12'h00C
`define PFC_OFS_CAPTOP 12'h010
`define PFC_OFS_FLAGS 12'h014
`define PFC_OFS_STATUS 12'h018

// Control register fields
`define PFC_CTRL_WGM_LSB 0
`define PFC_CTRL_WGM_MSB 3
`define PFC_CTRL_COMA_LSB 4
`define PFC_CTRL_COMA_MSB 5
`define PFC_CTRL_COMB_LSB 6
`define PFC_CTRL_COMB_MSB 7
`define PFC_CTRL_CS_LSB 8
`define PFC_CTRL_CS_MSB 10
`define PFC_CTRL_DIRA_BIT 11
`define PFC_CTRL_DIRB_BIT 12
`define PFC_CTRL_RESET 13'h0

// Flag register bits
`define PFC_FLAG_OVF_BIT 0
`define PFC_FLAG_CMPA_BIT 1
`define PFC_FLAG_CMPB_BIT 2
`define PFC_FLAG_CAP_BIT 3

// Status register bits
`define PFC_STAT_DOWN_BIT 0
`define PFC_STAT_OCA_BIT 1
`define PFC_STAT_OCB_BIT 2

// Waveform modes
`define PFC_WGM_CAPTOP 4'h8
`define PFC_WGM_CMPATOP 4'h9

// Compare output modes
`define PFC_COM_OFF 2'h0
`define PFC_COM_TOGGLE 2'h1
`define PFC_COM_NONINV 2'h2
`define PFC_COM_INV 2'h3

// Clock select codes
`define PFC_CS_STOP 3'h0
`define PFC_CS_DIV1 3'h1
`define PFC_CS_DIV8 3'h2
`define PFC_CS_DIV64 3'h3
`define PFC_CS_DIV256 3'h4
`define PFC_CS_DIV1024 3'h5

// Prescale terminal counts (factor minus one)
`define PFC_TC_DIV1 10'h000
`define PFC_TC_DIV8 10'h007
`define PFC_TC_DIV64 10'h03F
`define PFC_TC_DIV256 10'h0FF
`define PFC_TC_DIV1024 10'h3FF

// Reset values
`define PFC_COUNT_RESET 16'h0000
`define PFC_CMP_RESET 16'h0000
`define PFC_CAPTOP_RESET 16'h0000

`endif

// ==== pfc_prescaler.v ====
// Timer tick enable generator from the I/O clock
`timescale 1ns/1ns
`default_nettype none
`include "pfc_defs.vh"

module pfc_prescaler
(
   input wire clk, // I/O clock
   input wire reset_n, // Async reset, active low
   input wire [2:0] clock_select, // Prescale select
   output wire timer_tick // One-cycle enable
);

   reg [9:0] div_count;
   reg [9:0] terminal;
   reg running;

   // ****************************************
   // Terminal count decode
   // ****************************************
   always @*
   begin
      running = 1'b1;
      case (clock_select)
         `PFC_CS_DIV1: terminal = `PFC_TC_DIV1;
         `PFC_CS_DIV8: terminal = `PFC_TC_DIV8;
         `PFC_CS_DIV64: terminal = `PFC_TC_DIV64;
         `PFC_CS_DIV256: terminal = `PFC_TC_DIV256;
         `PFC_CS_DIV1024: terminal = `PFC_TC_DIV1024;
         default:
         begin
            terminal = `PFC_TC_DIV1;
            running = 1'b0;
         end
      endcase
   end

   // ****************************************
   // Divider
   // ****************************************
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         div_count <= 10'h000;
      else if (!running || div_count >= terminal)
         div_count <= 10'h000;
      else
         div_count <= div_count + 10'h001;
   end

   assign timer_tick = running && (div_count >= terminal); // [R16] [R17]

endmodule // pfc_prescaler

`default_nettype wire

// ==== pfc_channel.v ====
// One compare channel: buffered compare value and waveform output
`timescale 1ns/1ns
`default_nettype none
`include "pfc_defs.vh"

module pfc_channel
(
   input wire clk, // I/O clock
   input wire reset_n, // Async reset, active low
   input wire timer_tick, // Timer clock enable
   input wire pwm_active, // Frequency-correct mode selected
   input wire load_now, // Counter at bottom on a tick
   input wire [15:0] buffer_value, // Compare buffer from software
   input wire [15:0] counter_value, // Current count
   input wire [15:0] top_value, // Current top
   input wire counting_down, // Direction of count
   input wire [1:0] compare_output_mode, // Output mode field
   input wire toggle_allowed, // Toggle mode permitted here
   output reg [15:0] compare_value, // Active compare value
   output wire match, // Count equals compare on a tick
   output reg compare_output // Waveform state
);

   wire at_bottom;
   wire at_top;
   wire set_level;

   assign at_bottom = (counter_value == 16'h0000);
   assign at_top = (counter_value == top_value);
   assign match = pwm_active && timer_tick && (counter_value == compare_value);

   // Bottom counts as the up slope, top as the down slope, for the extremes
   assign set_level = at_bottom ? 1'b0 : (at_top ? 1'b1 : counting_down);

   // ****************************************
   // Double buffer
   // ****************************************
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         compare_value <= `PFC_CMP_RESET;
      else if (!pwm_active || load_now)
         compare_value <= buffer_value; // [R8]
   end

   // ****************************************
   // Waveform
   // ****************************************
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         compare_output <= 1'b0; // [R21]
      else if (match)
      begin
         case (compare_output_mode)
            `PFC_COM_NONINV: compare_output <= set_level; // [R3] [R4] [R14]
            `PFC_COM_INV: compare_output <= ~set_level; // [R3] [R4] [R14]
            `PFC_COM_TOGGLE:
            begin
               if (toggle_allowed)
                  compare_output <= ~compare_output; // [R15]
            end
            default: compare_output <= compare_output;
         endcase
      end
   end

endmodule // pfc_channel

`default_nettype wire

// ==== pfc_timer.v ====
// Dual-slope frequency-correct PWM timer with APB register access
//
// Behaviour
// [R1] Modes 0x8 and 0x9 select this operation
// [R2] Count up from zero to top, back
// [R3] Non-inverting: clear up-match, set down-match
// [R4] Output mode 0x2 non-inverted, 0x3 inverted
// [R5] Top from capture (0x8) or compare A (0x9)
// [R6] Counter holds top for one tick
// [R7] Software keeps top at least 0x0003
// [R8] Compare registers reload only at bottom
// [R9] Overflow flag set with bottom reload
// [R10] Match flag set when count equals compare
// [R11] Top-defining flag set when reaching top
// [R12] Software keeps top above compare values
// [R13] Waveform on pin only when output direction
// [R14] Compare bottom gives low, top gives high
// [R15] Mode 0x9 with toggle gives 50% duty
// [R16] Tick is clock over 1/8/64/256/1024
// [R17] Fully synchronous, tick is an enable
// [R18] Period is twice top times prescale
// [R19] Capture top frees compare A for PWM
// [R20] Output mode zero leaves port control
// [R21] Reset clears counter, outputs, flags; counts up
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "pfc_defs.vh"

module pfc_timer
(
   input wire clk, // I/O clock, 125 MHz
   input wire reset_n, // Async reset, active low
   input wire psel, // APB select
   input wire penable, // APB access phase
   input wire pwrite, // APB write
   input wire [11:0] paddr, // APB byte address
   input wire [31:0] pwdata, // APB write data
   input wire [3:0] pstrb, // APB byte strobes
   output wire pready, // APB ready
   output reg [31:0] prdata, // APB read data
   output reg pslverr, // APB error on unmapped address
   input wire port_data_a, // Normal port value for pin A
   input wire port_data_b, // Normal port value for pin B
   output reg pin_a_out, // Pin A level
   output reg pin_a_oe_n, // Pin A drive enable, low drives
   output reg pin_b_out, // Pin B level
   output reg pin_b_oe_n // Pin B drive enable, low drives
);

   // ****************************************
   // Declarations
   // ****************************************
   reg [12:0] ctrl;
   reg [15:0] cmp_buf_a;
   reg [15:0] cmp_buf_b;
   reg [15:0] capture_top_value;
   reg [15:0] counter_value;
   reg counting_down;
   reg overflow_flag;
   reg compare_match_flag_a;
   reg compare_match_flag_b;
   reg capture_flag;
   reg [15:0] next_count;
   reg next_down;
   reg [31:0] next_rdata;
   reg next_err;

   wire [3:0] waveform_mode_select;
   wire [1:0] compare_output_mode_a;
   wire [1:0] compare_output_mode_b;
   wire [2:0] clock_select;
   wire pin_direction_bit_a;
   wire pin_direction_bit_b;
   wire pwm_active;
   wire cap_top;
   wire timer_tick;
   wire [15:0] compare_value_a;
   wire [15:0] compare_value_b;
   wire [15:0] top_value;
   wire match_a;
   wire match_b;
   wire compare_output_a;
   wire compare_output_b;
   wire at_bottom;
   wire at_top;
   wire load_now;
   wire wr_access;
   wire rd_setup;
   wire clr_flags;
   wire mode_a_on;
   wire mode_b_on;

   assign waveform_mode_select = ctrl[`PFC_CTRL_WGM_MSB:`PFC_CTRL_WGM_LSB];
   assign compare_output_mode_a = ctrl[`PFC_CTRL_COMA_MSB:`PFC_CTRL_COMA_LSB];
   assign compare_output_mode_b = ctrl[`PFC_CTRL_COMB_MSB:`PFC_CTRL_COMB_LSB];
   assign clock_select = ctrl[`PFC_CTRL_CS_MSB:`PFC_CTRL_CS_LSB];
   assign pin_direction_bit_a = ctrl[`PFC_CTRL_DIRA_BIT];
   assign pin_direction_bit_b = ctrl[`PFC_CTRL_DIRB_BIT];

   // ****************************************
   // Mode and top selection
   // ****************************************
   assign pwm_active = (waveform_mode_select == `PFC_WGM_CAPTOP) ||
                       (waveform_mode_select == `PFC_WGM_CMPATOP); // [R1]
   assign cap_top = (waveform_mode_select == `PFC_WGM_CAPTOP);
   assign top_value = cap_top ? capture_top_value : compare_value_a; // [R5] [R19]
   assign at_bottom = (counter_value == 16'h0000);
   assign at_top = (counter_value == top_value);
   assign load_now = pwm_active && timer_tick && at_bottom; // [R8] [R9]

   // ****************************************
   // Tick and channels
   // ****************************************
   pfc_prescaler u_prescaler
   (
      .clk(clk),
      .reset_n(reset_n),
      .clock_select(clock_select),
      .timer_tick(timer_tick)
   );

   pfc_channel u_channel_a
   (
      .clk(clk),
      .reset_n(reset_n),
      .timer_tick(timer_tick),
      .pwm_active(pwm_active),
      .load_now(load_now),
      .buffer_value(cmp_buf_a),
      .counter_value(counter_value),
      .top_value(top_value),
      .counting_down(counting_down),
      .compare_output_mode(compare_output_mode_a),
      .toggle_allowed(!cap_top),
      .compare_value(compare_value_a),
      .match(match_a),
      .compare_output(compare_output_a)
   );

   pfc_channel u_channel_b
   (
      .clk(clk),
      .reset_n(reset_n),
      .timer_tick(timer_tick),
      .pwm_active(pwm_active),
      .load_now(load_now),
      .buffer_value(cmp_buf_b),
      .counter_value(counter_value),
      .top_value(top_value),
      .counting_down(counting_down),
      .compare_output_mode(compare_output_mode_b),
      .toggle_allowed(1'b0),
      .compare_value(compare_value_b),
      .match(match_b),
      .compare_output(compare_output_b)
   );

   // ****************************************
   // Dual-slope counter
   // ****************************************
   always @*
   begin
      next_count = counter_value;
      next_down = counting_down;
      if (!pwm_active)
      begin
         next_count = `PFC_COUNT_RESET;
         next_down = 1'b0;
      end
      else if (timer_tick)
      begin
         if (!counting_down)
         begin
            if (at_top)
            begin
               next_count = counter_value - 16'h0001; // [R6]
               next_down = 1'b1; // [R2] [R5]
            end
            else
               next_count = counter_value + 16'h0001; // [R2]
         end
         else
         begin
            if (at_bottom)
            begin
               next_count = counter_value + 16'h0001; // [R2] [R18]
               next_down = 1'b0;
            end
            else
               next_count = counter_value - 16'h0001; // [R2]
         end
      end
   end

   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         counter_value <= `PFC_COUNT_RESET; // [R21]
         counting_down <= 1'b0; // [R21]
      end
      else
      begin
         counter_value <= next_count; // [R17]
         counting_down <= next_down;
      end
   end

   // ****************************************
   // Event flags, set wins over clear
   // ****************************************
   assign wr_access = psel && penable && pwrite;
   assign clr_flags = wr_access && (paddr == `PFC_OFS_FLAGS) && pstrb[0];

   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         overflow_flag <= 1'b0; // [R21]
         compare_match_flag_a <= 1'b0;
         compare_match_flag_b <= 1'b0;
         capture_flag <= 1'b0;
      end
      else
      begin
         if (load_now)
            overflow_flag <= 1'b1; // [R9]
         else if (clr_flags && pwdata[`PFC_FLAG_OVF_BIT])
            overflow_flag <= 1'b0;
         if (match_a)
            compare_match_flag_a <= 1'b1; // [R10] [R11]
         else if (clr_flags && pwdata[`PFC_FLAG_CMPA_BIT])
            compare_match_flag_a <= 1'b0;
         if (match_b)
            compare_match_flag_b <= 1'b1; // [R10]
         else if (clr_flags && pwdata[`PFC_FLAG_CMPB_BIT])
            compare_match_flag_b <= 1'b0;
         if (pwm_active && cap_top && timer_tick && at_top && !counting_down)
            capture_flag <= 1'b1; // [R11]
         else if (clr_flags && pwdata[`PFC_FLAG_CAP_BIT])
            capture_flag <= 1'b0;
      end
   end

   // ****************************************
   // Pin control
   // ****************************************
   assign mode_a_on = (compare_output_mode_a == `PFC_COM_NONINV) ||
                      (compare_output_mode_a == `PFC_COM_INV) ||
                      ((compare_output_mode_a == `PFC_COM_TOGGLE) && !cap_top);
   assign mode_b_on = (compare_output_mode_b == `PFC_COM_NONINV) ||
                      (compare_output_mode_b == `PFC_COM_INV);

   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pin_a_out <= 1'b0;
         pin_a_oe_n <= 1'b1;
         pin_b_out <= 1'b0;
         pin_b_oe_n <= 1'b1;
      end
      else
      begin
         pin_a_out <= (pwm_active && mode_a_on) ? compare_output_a : port_data_a; // [R20]
         pin_a_oe_n <= !pin_direction_bit_a; // [R13]
         pin_b_out <= (pwm_active && mode_b_on) ? compare_output_b : port_data_b; // [R20]
         pin_b_oe_n <= !pin_direction_bit_b; // [R13]
      end
   end

   // ****************************************
   // APB register writes
   // ****************************************
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ctrl <= `PFC_CTRL_RESET;
         cmp_buf_a <= `PFC_CMP_RESET;
         cmp_buf_b <= `PFC_CMP_RESET;
         capture_top_value <= `PFC_CAPTOP_RESET;
      end
      else if (wr_access)
      begin
         case (paddr)
            `PFC_OFS_CTRL:
            begin
               if (pstrb[0])
                  ctrl[7:0] <= pwdata[7:0];
               if (pstrb[1])
                  ctrl[12:8] <= pwdata[12:8];
            end
            `PFC_OFS_CMPA:
            begin
               if (pstrb[0])
                  cmp_buf_a[7:0] <= pwdata[7:0];
               if (pstrb[1])
                  cmp_buf_a[15:8] <= pwdata[15:8];
            end
            `PFC_OFS_CMPB:
            begin
               if (pstrb[0])
                  cmp_buf_b[7:0] <= pwdata[7:0];
               if (pstrb[1])
                  cmp_buf_b[15:8] <= pwdata[15:8];
            end
            `PFC_OFS_CAPTOP:
            begin
               if (pstrb[0])
                  capture_top_value[7:0] <= pwdata[7:0];
               if (pstrb[1])
                  capture_top_value[15:8] <= pwdata[15:8];
            end
            default: ctrl <= ctrl;
         endcase
      end
   end

   // ****************************************
   // APB read data, captured in setup phase
   // ****************************************
   assign rd_setup = psel && !penable;
   assign pready = 1'b1;

   always @*
   begin
      next_rdata = 32'h00000000;
      next_err = 1'b0;
      case (paddr)
         `PFC_OFS_CTRL: next_rdata = {19'h0, ctrl};
         `PFC_OFS_COUNT: next_rdata = {16'h0000, counter_value};
         `PFC_OFS_CMPA: next_rdata = {16'h0000, cmp_buf_a};
         `PFC_OFS_CMPB: next_rdata = {16'h0000, cmp_buf_b};
         `PFC_OFS_CAPTOP: next_rdata = {16'h0000, capture_top_value};
         `PFC_OFS_FLAGS: next_rdata = {28'h0000000, capture_flag, compare_match_flag_b,
                                       compare_match_flag_a, overflow_flag};
         `PFC_OFS_STATUS: next_rdata = {29'h0, compare_output_b, compare_output_a,
                                        counting_down};
         default: next_err = 1'b1;
      endcase
   end

   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end
      else if (rd_setup)
      begin
         prdata <= pwrite ? 32'h00000000 : next_rdata;
         pslverr <= next_err;
      end
   end

endmodule // pfc_timer

`default_nettype wire

// ==== pfc_timer_monitor.sv ====
// Port checker for the PWM timer
`timescale 1ns/1ns
`default_nettype none
module pfc_timer_mon
(
   input wire logic clk, // Clock
   input wire logic reset_n, // Reset
   input wire logic psel, // Select
   input wire logic penable, // Access
   input wire logic pwrite, // Write
   input wire logic [11:0] paddr, // Address
   input wire logic [31:0] pwdata, // Write data
   input wire logic [3:0] pstrb, // Strobes
   input wire logic pready, // Ready
   input wire logic [31:0] prdata, // Read data
   input wire logic pslverr, // Error
   input wire logic port_data_a, // Port A
   input wire logic port_data_b, // Port B
   input wire logic pin_a_out, // Pin A
   input wire logic pin_a_oe_n, // Pin A enable
   input wire logic pin_b_out, // Pin B
   input wire logic pin_b_oe_n // Pin B enable
);
   logic [12:0] ctl;
   // Shadow of the control register
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         ctl <= 13'h0000;
      else if (psel && penable && pwrite && paddr == 12'h000)
         ctl <= pwdata[12:0];
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   AST_DIR_ON_A: assert property (ctl[11] && $past(ctl[11]) |-> !pin_a_oe_n)
      else $error("pin A not driven");
   AST_DIR_OFF_A: assert property (!ctl[11] && !$past(ctl[11]) |-> pin_a_oe_n)
      else $error("pin A driven");
   AST_DIR_ON_B: assert property (ctl[12] && $past(ctl[12]) |-> !pin_b_oe_n)
      else $error("pin B not driven");
   AST_DIR_OFF_B: assert property (!ctl[12] && !$past(ctl[12]) |-> pin_b_oe_n)
      else $error("pin B driven");
   AST_PORT_A: assert property (ctl[5:4] == 2'h0 && $past(ctl[5:4]) == 2'h0 && $stable(port_data_a) |->
      pin_a_out == port_data_a) else $error("pin A not port");
   AST_PORT_B: assert property (ctl[7:6] == 2'h0 && $past(ctl[7:6]) == 2'h0 && $stable(port_data_b) |->
      pin_b_out == port_data_b) else $error("pin B not port");
   AST_READY: assert property (psel && penable |-> pready)
      else $error("ready low");
   AST_ERR: assert property (psel && penable && paddr > 12'h01B |-> pslverr)
      else $error("no error on unmapped");
   COV_PWM: cover property (ctl[3:0] == 4'h8 && $rose(pin_a_out));
   COV_TOG: cover property (ctl[3:0] == 4'h9 && $fell(pin_a_out));
   COV_ERR: cover property (pslverr);
endmodule // pfc_timer_mon
bind pfc_timer pfc_timer_mon u_mon (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
   .pslverr(pslverr), .port_data_a(port_data_a), .port_data_b(port_data_b), .pin_a_out(pin_a_out),
   .pin_a_oe_n(pin_a_oe_n), .pin_b_out(pin_b_out), .pin_b_oe_n(pin_b_oe_n));
`default_nettype wire

// ==== pfc_load.sv ====
// Pin load model with pull-down and run length meter
`timescale 1ns/1ns
`default_nettype none
module pfc_load
(
   input wire logic clk, // Clock
   input wire logic pin_out, // Driven level
   input wire logic pin_oe_n, // Low drives
   output logic level, // Resolved pin
   output logic [15:0] hi_len, // Last high run
   output logic [15:0] lo_len // Last low run
);
   logic [15:0] run = 16'h0000;
   logic last = 1'b0;
   // Pull-down when released
   assign level = pin_oe_n ? 1'b0 : pin_out;
   always @(posedge clk)
   begin
      last <= level;
      if (level != last)
      begin
         run <= 16'h0001;
         if (last)
            hi_len <= run;
         else
            lo_len <= run;
      end
      else
         run <= run + 16'h0001;
   end
endmodule // pfc_load
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the PWM timer
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [3:0] pstrb = 4'hF;
   logic port_data_a = 1'b0;
   logic port_data_b = 1'b0;
   wire pready;
   wire pslverr;
   wire [31:0] prdata;
   wire pin_a_out;
   wire pin_a_oe_n;
   wire pin_b_out;
   wire pin_b_oe_n;
   wire level_a;
   wire level_b;
   wire [15:0] hi_a;
   wire [15:0] lo_a;
   wire [15:0] hi_b;
   wire [15:0] lo_b;
   int n_fail = 0;
   int comparisons = 0;
   int cycles = 0;
   int div [5] = '{1, 8, 64, 256, 1024};
   logic [31:0] rd;
   logic err;
   pfc_timer dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .port_data_a(port_data_a), .port_data_b(port_data_b), .pin_a_out(pin_a_out),
      .pin_a_oe_n(pin_a_oe_n), .pin_b_out(pin_b_out), .pin_b_oe_n(pin_b_oe_n));
   pfc_load load_a (.clk(clk), .pin_out(pin_a_out), .pin_oe_n(pin_a_oe_n), .level(level_a),
      .hi_len(hi_a), .lo_len(lo_a));
   pfc_load load_b (.clk(clk), .pin_out(pin_b_out), .pin_oe_n(pin_b_oe_n), .level(level_b),
      .hi_len(hi_b), .lo_len(lo_b));
   initial
   begin
      forever #4 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 60000)
      begin
         n_fail = n_fail + 1;
         end_of_test();
      end
   end
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One APB transfer; data taken at the ready edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [31:0] ctrl(input logic [3:0] m, input logic [1:0] ca, input logic [1:0] cb,
      input logic [2:0] cs);
      ctrl = {19'h0, 2'h3, cs, cb, ca, m};
   endfunction
   task automatic t_reset;
      check("oe_n a", 32'h1, 32'(pin_a_oe_n));
      apb(1'b0, 12'h004, 32'h0);
      check("count", 32'h0, rd);
      apb(1'b0, 12'h014, 32'h0);
      check("flags", 32'h0, rd);
      apb(1'b0, 12'h018, 32'h0);
      check("status", 32'h0, rd);
      apb(1'b0, 12'h01C, 32'h0);
      check("slverr", 32'h1, 32'(err));
      $display("test reset done");
   endtask
   task automatic t_port;
      apb(1'b1, 12'h000, 32'h00000800);
      port_data_a <= 1'b1;
      repeat (3) @(posedge clk);
      check("level a", 32'h1, 32'(level_a));
      port_data_a <= 1'b0;
      repeat (3) @(posedge clk);
      check("pin a", 32'h0, 32'(pin_a_out));
      apb(1'b1, 12'h000, 32'h0);
      repeat (3) @(posedge clk);
      check("oe_n a", 32'h1, 32'(pin_a_oe_n));
      $display("test port done");
   endtask
   task automatic t_prescale;
      apb(1'b1, 12'h010, 32'h5);
      apb(1'b1, 12'h008, 32'h1);
      apb(1'b1, 12'h00C, 32'h2);
      for (int cs = 1; cs <= 5; cs++)
      begin
         apb(1'b1, 12'h000, ctrl(4'h8, 2'h2, 2'h3, 3'(cs)));
         repeat (30 * div[cs - 1]) @(posedge clk);
         check("hi a", 2 * div[cs - 1], 32'(hi_a));
         check("lo a", 8 * div[cs - 1], 32'(lo_a));
         check("hi b", 6 * div[cs - 1], 32'(hi_b));
         check("lo b", 4 * div[cs - 1], 32'(lo_b));
      end
      $display("test prescale done");
   endtask
   task automatic t_toggle;
      // Leave the mode first so the counter restarts at bottom below the new top
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b1, 12'h008, 32'h5);
      apb(1'b1, 12'h00C, 32'h1);
      apb(1'b1, 12'h000, ctrl(4'h9, 2'h1, 2'h2, 3'h1));
      repeat (60) @(posedge clk);
      check("hi a", 32'd10, 32'(hi_a));
      check("lo a", 32'd10, 32'(lo_a));
      check("hi b", 32'd2, 32'(hi_b));
      check("lo b", 32'd8, 32'(lo_b));
      $display("test toggle done");
   endtask
   task automatic t_extreme;
      int sa;
      int sb;
      sa = 0;
      sb = 0;
      apb(1'b1, 12'h008, 32'h0);
      apb(1'b1, 12'h00C, 32'h5);
      apb(1'b1, 12'h000, ctrl(4'h8, 2'h2, 2'h2, 3'h1));
      repeat (30) @(posedge clk);
      repeat (20)
      begin
         @(posedge clk);
         sa += level_a;
         sb += level_b;
      end
      check("high a", 32'd0, 32'(sa));
      check("high b", 32'd20, 32'(sb));
      $display("test extreme done");
   endtask
   task automatic t_flags;
      apb(1'b1, 12'h000, ctrl(4'h8, 2'h2, 2'h2, 3'h0));
      apb(1'b0, 12'h014, 32'h0);
      check("flags", 32'hF, rd);
      apb(1'b1, 12'h014, 32'hF);
      apb(1'b0, 12'h014, 32'h0);
      check("flags", 32'h0, rd);
      $display("test flags done");
   endtask
   // Reset while the counter runs and outputs are high
   task automatic t_midreset;
      apb(1'b1, 12'h000, ctrl(4'h8, 2'h3, 2'h2, 3'h1));
      repeat (13) @(posedge clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      t_reset();
      $display("test midreset done");
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      t_reset();
      t_port();
      t_prescale();
      t_toggle();
      t_extreme();
      t_flags();
      t_midreset();
      end_of_test();
   end
endmodule // testbench
`default_nettype wire
